// ==== pkg/stop_go_pkg.sv ====
// Shared constants and types for the stop/go bit control block
package stop_go_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLOCK_PERIOD_NS = 100;
    localparam int T1_TIME_US = 500;
    localparam int T1_CYCLES = T1_TIME_US * 1000 / CLOCK_PERIOD_NS;
    localparam real TD1_MIN_TIME_MS = 7.5;
    localparam real TD1_MAX_TIME_MS = 15.0;
    localparam int TD1_POS_STEPS = 15;
    localparam int TD1_MIN_CYCLES = int'(TD1_MIN_TIME_MS * 1000.0) * 1000 / CLOCK_PERIOD_NS;
    localparam int TD1_MAX_CYCLES = int'(TD1_MAX_TIME_MS * 1000.0) * 1000 / CLOCK_PERIOD_NS;
    localparam int TD1_STEP_CYCLES = (TD1_MAX_CYCLES - TD1_MIN_CYCLES) / TD1_POS_STEPS;
    localparam int CNT_W = 18;

    // ----------------------------------------------------------------
    // Frame layout
    // ----------------------------------------------------------------
    localparam int SLOT_BITS = 32;
    localparam int FRAME_SLOTS = 3;
    localparam int BIT_CNT_W = 7;
    localparam logic [BIT_CNT_W-1:0] FRAME_LAST_BIT = 7'(SLOT_BITS * FRAME_SLOTS - 1);
    localparam logic [BIT_CNT_W-1:0] SG_BIT_POS = 7'(SLOT_BITS * 2 + 27);
    localparam logic [BIT_CNT_W-1:0] D_BIT_POS = 7'h18;
    localparam logic [7:0] EOC_STOP_CODE = 8'h25;
    localparam logic [7:0] EOC_GO_CODE = 8'h27;
    localparam logic SG_STOP = 1'b1;
    localparam logic SG_GO = 1'b0;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h00;
    localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h04;
    localparam int CTRL_TERMINAL_BIT = 0;
    localparam int CTRL_SGL_BIT = 1;
    localparam int CTRL_BS_BIT = 2;
    localparam int CTRL_CBAC_BIT = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_SG_Z_BIT = 6;
    localparam int STAT_SG_BIT = 7;
    localparam int STAT_D0_BIT = 8;
    localparam int STAT_BAC_BIT = 9;
    localparam int STAT_HOST_BUS_MODE_SELECT_BIT = 10;
    localparam int STAT_ACT_BIT = 11;
    localparam int STAT_T1_BIT = 12;
    localparam int STAT_TD1_BIT = 14;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_OFF = 6'h01,
        ST_NOSYNC = 6'h02,
        ST_GO = 6'h04,
        ST_WAIT_STOP = 6'h08,
        ST_STOPPED = 6'h10,
        ST_RESUME = 6'h20
    } sg_state_t;

    typedef struct packed {
        logic valid;
        logic [7:0] code;
        logic [3:0] pos;
    } eoc_msg_t;

    typedef struct packed {
        logic valid;
        logic [1:0] bits;
    } d_up_t;

endpackage

// ==== logic/pin_sync.sv ====
// Three-stage pin synchroniser with agreement filter
module pin_sync
    import stop_go_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] level_o
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] lvl;
    } sync_t;

    sync_t q;
    sync_t n;

    // Stage one feeds stage two only; a change counts when two and three agree
    always_comb begin
        n = q;
        n.s1 = pin_i;
        n.s2 = q.s1;
        n.s3 = q.s2;
        for (int i = 0; i < WIDTH; i++) begin
            if (q.s2[i] == q.s3[i]) begin
                n.lvl[i] = q.s3[i];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign level_o = q.lvl;

endmodule

// ==== logic/stop_go_ctrl.sv ====
// Stop/go bit control for terminal mode with AXI4-Lite registers
//
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
module stop_go_ctrl
    import stop_go_pkg::*;
#(
    parameter int T1_CYC = T1_CYCLES,
    parameter int TD1_MIN_CYC = TD1_MIN_CYCLES,
    parameter int TD1_STEP_CYC = TD1_STEP_CYCLES
) (
    input wire logic CLOCK_I,
    input wire logic RESET_I,
    input wire logic [ADDR_W-1:0] AXI_AWADDR_I,
    input wire logic AXI_AWVALID_I,
    output logic AXI_AWREADY_O,
    input wire logic [31:0] AXI_WDATA_I,
    input wire logic [3:0] AXI_WSTRB_I,
    input wire logic AXI_WVALID_I,
    output logic AXI_WREADY_O,
    output logic [1:0] AXI_BRESP_O,
    output logic AXI_BVALID_O,
    input wire logic AXI_BREADY_I,
    input wire logic [ADDR_W-1:0] AXI_ARADDR_I,
    input wire logic AXI_ARVALID_I,
    output logic AXI_ARREADY_O,
    output logic [31:0] AXI_RDATA_O,
    output logic [1:0] AXI_RRESP_O,
    output logic AXI_RVALID_O,
    input wire logic AXI_RREADY_I,
    input wire logic FRAME_SYNC_I,
    input wire logic BIT_CLOCK_I,
    input wire logic DATA_IN_I,
    output logic DATA_OUT_O,
    output logic DATA_OUT_OE_O,
    input wire logic HOST_BUS_MODE_SELECT_I,
    input wire logic RX_SYNC_I,
    input wire eoc_msg_t EOC_MSG_I,
    output d_up_t D_UP_O
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        sg_state_t st;
        logic clk_prev;
        logic [BIT_CNT_W-1:0] bit_cnt;
        logic dout;
        logic dout_oe;
        logic bus_access_bit_in;
        logic d_first;
        d_up_t d_up;
        logic d_channel_zero_force;
        logic t1_run;
        logic t1_exp;
        logic [CNT_W-1:0] t1_cnt;
        logic td1_run;
        logic td1_exp;
        logic [CNT_W-1:0] td1_cnt;
        logic [3:0] ctrl;
        logic host_bus_mode_select;
        logic receiver_sync_flag;
        logic aw_hold;
        logic [ADDR_W-1:0] aw_addr;
        logic w_hold;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ctrl_state_t;

    ctrl_state_t q;
    ctrl_state_t n;
    logic [2:0] pins;
    logic link_clk;
    logic link_fs;
    logic link_din;
    logic host_bus_mode_select_pin;
    logic terminal_mode_flag;
    logic stop_cmd;
    logic go_cmd;
    logic sw_stop;
    logic bac_eff;
    logic rise;
    logic fall;
    logic sg_val;
    logic sg_z;
    logic [31:0] status;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    pin_sync #(
        .WIDTH(4)
    ) u_sync (
        .clk_i(CLOCK_I),
        .rst_i(RESET_I),
        .pin_i({HOST_BUS_MODE_SELECT_I, FRAME_SYNC_I, BIT_CLOCK_I, DATA_IN_I}),
        .level_o({host_bus_mode_select_pin, pins})
    );

    assign link_fs = pins[2];
    assign link_clk = pins[1];
    assign link_din = pins[0];

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        n = q;
        terminal_mode_flag = q.ctrl[CTRL_TERMINAL_BIT];
        n.host_bus_mode_select = host_bus_mode_select_pin;
        n.receiver_sync_flag = RX_SYNC_I;
        stop_cmd = EOC_MSG_I.valid && EOC_MSG_I.code == EOC_STOP_CODE;
        go_cmd = EOC_MSG_I.valid && EOC_MSG_I.code == EOC_GO_CODE;
        // SGL and BS bits only count when a host bus exists; CBAC counts regardless
        sw_stop = q.host_bus_mode_select && q.ctrl[CTRL_SGL_BIT];
        bac_eff = q.bus_access_bit_in && !q.ctrl[CTRL_CBAC_BIT];
        rise = link_clk && !q.clk_prev;
        fall = !link_clk && q.clk_prev;
        n.clk_prev = link_clk;
        n.d_up.valid = 1'b0;

        // Timers
        if (q.t1_run) begin
            if (q.t1_cnt == CNT_W'(1)) begin
                n.t1_run = 1'b0;
                n.t1_exp = 1'b1;
            end else begin
                n.t1_cnt = q.t1_cnt - CNT_W'(1);
            end
        end
        if (q.td1_run) begin
            if (q.td1_cnt == CNT_W'(1)) begin
                n.td1_run = 1'b0;
                n.td1_exp = 1'b1;
            end else begin
                n.td1_cnt = q.td1_cnt - CNT_W'(1);
            end
        end

        // Stop/go transitions
        if (!terminal_mode_flag) begin
            n.st = ST_OFF;
        end else if (!q.receiver_sync_flag) begin
            n.st = ST_NOSYNC;
        end else begin
            unique case (q.st)
                ST_OFF, ST_NOSYNC: begin
                    n.st = ST_GO;
                end
                ST_GO: begin
                    if (stop_cmd || sw_stop) begin
                        n.st = ST_WAIT_STOP;
                        n.t1_run = 1'b1;
                        n.t1_exp = 1'b0;
                        n.t1_cnt = CNT_W'(T1_CYC);
                    end
                end
                ST_WAIT_STOP: begin
                    // Let a running controller access finish before forcing zeros
                    if (q.t1_exp || !bac_eff) begin
                        n.st = ST_STOPPED;
                    end
                end
                ST_STOPPED: begin
                    if (go_cmd && !sw_stop) begin
                        n.st = ST_RESUME;
                        n.td1_run = 1'b1;
                        n.td1_exp = 1'b0;
                        n.td1_cnt = CNT_W'(TD1_MIN_CYC) + CNT_W'(TD1_STEP_CYC) * CNT_W'(EOC_MSG_I.pos);
                    end
                end
                ST_RESUME: begin
                    if (stop_cmd || sw_stop) begin
                        n.st = ST_STOPPED;
                        n.td1_run = 1'b0;
                    end else if (q.td1_exp && !(q.host_bus_mode_select && q.ctrl[CTRL_BS_BIT])) begin
                        n.st = ST_GO;
                    end
                end
            endcase
        end
        n.d_channel_zero_force = n.st == ST_STOPPED || n.st == ST_RESUME;
        sg_z = q.st == ST_OFF;
        sg_val = q.st == ST_GO ? SG_GO : SG_STOP;

        // Frame timing: drive on rising edge, sample on falling edge
        if (rise) begin
            if (link_fs) begin
                n.bit_cnt = '0;
            end else if (q.bit_cnt != FRAME_LAST_BIT) begin
                n.bit_cnt = q.bit_cnt + BIT_CNT_W'(1);
            end
            n.dout = sg_val;
            n.dout_oe = n.bit_cnt == SG_BIT_POS && !sg_z;
        end
        // Release at once on leaving terminal mode, not at the next link edge
        if (n.st == ST_OFF) begin
            n.dout_oe = 1'b0;
        end
        if (fall) begin
            if (q.bit_cnt == SG_BIT_POS) begin
                n.bus_access_bit_in = link_din;
            end
            if (q.bit_cnt == D_BIT_POS) begin
                n.d_first = link_din;
            end
            if (q.bit_cnt == D_BIT_POS + BIT_CNT_W'(1)) begin
                n.d_up.valid = 1'b1;
                n.d_up.bits = q.d_channel_zero_force ? 2'h0 : {q.d_first, link_din};
            end
        end

        // Status word
        status = '0;
        status[STAT_STATE_LSB +: 6] = q.st;
        status[STAT_SG_Z_BIT] = sg_z;
        status[STAT_SG_BIT] = sg_val;
        status[STAT_D0_BIT] = q.d_channel_zero_force;
        status[STAT_BAC_BIT] = q.bus_access_bit_in;
        status[STAT_HOST_BUS_MODE_SELECT_BIT] = q.host_bus_mode_select;
        status[STAT_ACT_BIT] = q.receiver_sync_flag;
        status[STAT_T1_BIT +: 2] = {q.t1_exp, q.t1_run};
        status[STAT_TD1_BIT +: 2] = {q.td1_exp, q.td1_run};

        // AXI4-Lite write: address and data in either order
        if (q.awready && AXI_AWVALID_I) begin
            n.aw_hold = 1'b1;
            n.aw_addr = AXI_AWADDR_I;
        end
        if (q.wready && AXI_WVALID_I) begin
            n.w_hold = 1'b1;
            n.w_data = AXI_WDATA_I;
            n.w_strb = AXI_WSTRB_I;
        end
        if (q.bvalid && AXI_BREADY_I) begin
            n.bvalid = 1'b0;
        end
        if (q.aw_hold && q.w_hold && !q.bvalid) begin
            n.aw_hold = 1'b0;
            n.w_hold = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = RESP_OKAY;
            if (q.aw_addr[ADDR_W-1:2] == CTRL_OFFSET[ADDR_W-1:2]) begin
                if (q.w_strb[0]) begin
                    n.ctrl = q.w_data[3:0];
                end
            end else if (q.aw_addr[ADDR_W-1:2] != STATUS_OFFSET[ADDR_W-1:2]) begin
                n.bresp = RESP_SLVERR;
            end
        end
        n.awready = !n.aw_hold && !n.bvalid;
        n.wready = !n.w_hold && !n.bvalid;

        // AXI4-Lite read
        if (q.rvalid && AXI_RREADY_I) begin
            n.rvalid = 1'b0;
        end
        if (q.arready && AXI_ARVALID_I) begin
            n.rvalid = 1'b1;
            n.rresp = RESP_OKAY;
            if (AXI_ARADDR_I[ADDR_W-1:2] == CTRL_OFFSET[ADDR_W-1:2]) begin
                n.rdata = {28'h000_0000, q.ctrl};
            end else if (AXI_ARADDR_I[ADDR_W-1:2] == STATUS_OFFSET[ADDR_W-1:2]) begin
                n.rdata = status;
            end else begin
                n.rdata = '0;
                n.rresp = RESP_SLVERR;
            end
        end
        n.arready = !n.rvalid;
    end

    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            q <= '0;
            q.st <= ST_OFF;
            q.ctrl <= CTRL_RESET;
        end else begin
            q <= n;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign AXI_AWREADY_O = q.awready;
    assign AXI_WREADY_O = q.wready;
    assign AXI_BVALID_O = q.bvalid;
    assign AXI_BRESP_O = q.bresp;
    assign AXI_ARREADY_O = q.arready;
    assign AXI_RVALID_O = q.rvalid;
    assign AXI_RDATA_O = q.rdata;
    assign AXI_RRESP_O = q.rresp;
    assign DATA_OUT_O = q.dout;
    assign DATA_OUT_OE_O = q.dout_oe;
    assign D_UP_O = q.d_up;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLOCK_I);
    endclocking
    default disable iff (RESET_I);

    sg_slot_a: assert property (q.dout_oe |-> q.bit_cnt == SG_BIT_POS
        && (!$rose(q.dout_oe) || q.dout == ($past(q.st) == ST_GO ? SG_GO : SG_STOP)))
        else $error("stop/go driven outside its bit or with wrong value");
    sg_tristate_a: assert property (q.st == ST_OFF |-> !q.dout_oe)
        else $error("stop/go driven while in third state");
    d_zero_a: assert property (q.d_up.valid && $past(q.d_channel_zero_force) |-> q.d_up.bits == 2'h0)
        else $error("upstream D bits not forced to zero");
    bac_sample_a: assert property (fall && q.bit_cnt == SG_BIT_POS |=> q.bus_access_bit_in == $past(link_din))
        else $error("bus-access bit not sampled at its position");
    stop_cmd_a: assert property (q.st == ST_GO && stop_cmd && terminal_mode_flag && q.receiver_sync_flag
        |=> q.st == ST_WAIT_STOP ##1 q.st != ST_GO)
        else $error("stop command not taken");
    go_cmd_a: assert property (q.st == ST_STOPPED && go_cmd && !sw_stop && terminal_mode_flag && q.receiver_sync_flag
        |=> q.st == ST_RESUME && q.td1_run)
        else $error("go command not taken");
    t1_load_a: assert property (q.st == ST_WAIT_STOP && $past(q.st) == ST_GO |-> q.t1_run && q.t1_cnt == CNT_W'(T1_CYC))
        else $error("short wait timer not loaded");
    t1_expire_a: assert property (q.t1_run && q.t1_cnt == CNT_W'(1) |=> q.t1_exp && !q.t1_run)
        else $error("short wait timer expiry missing");
    td1_load_a: assert property (q.st == ST_RESUME && $past(q.st) == ST_STOPPED
        |-> q.td1_cnt == CNT_W'(TD1_MIN_CYC) + CNT_W'(TD1_STEP_CYC) * CNT_W'($past(EOC_MSG_I.pos)))
        else $error("ops frame timer loaded with wrong length");
    host_bus_mode_select_follow_a: assert property (host_bus_mode_select_pin != q.host_bus_mode_select |=> q.host_bus_mode_select == $past(host_bus_mode_select_pin))
        else $error("host bus mode does not follow pin");
    te_off_a: assert property (!terminal_mode_flag |=> q.st == ST_OFF && !q.dout_oe[*1])
        else $error("block active outside terminal mode");
    sync_loss_a: assert property (terminal_mode_flag && !q.receiver_sync_flag |=> q.st == ST_NOSYNC && !q.d_channel_zero_force)
        else $error("sync loss not handled");
    d0_state_a: assert property (q.d_channel_zero_force |-> q.st inside {ST_STOPPED, ST_RESUME})
        else $error("zero-force outside stopped states");

endmodule

// ==== bench/frame_partner.sv ====
// Frame controller model: link clock, frame sync, data in, stop/go capture
module frame_partner (
    output logic bit_clock_o,
    output logic frame_sync_o,
    output logic data_o,
    input wire logic data_out_i,
    input wire logic data_oe_i,
    input wire logic bac_i
);
    timeunit 1ns;
    timeprecision 1ns;
    int bit_n = 95;
    logic [7:0] frame_n = 8'h00;
    logic sg_seen = 1'b0, oe_seen = 1'b0, oe_pre = 1'b0;
    event frame_done;
    // ----
    // Free-running bit clock, 800 ns a bit
    // ----
    initial begin
        bit_clock_o = 1'b0;
        frame_sync_o = 1'b0;
        data_o = 1'b1;
        forever begin
            #400;
            bit_n = (bit_n == 95) ? 0 : bit_n + 1;
            bit_clock_o = 1'b1;
            if (bit_n == 0) frame_n = frame_n + 8'h01;
            if (bit_n == 91) oe_pre = data_oe_i;
            if (bit_n == 92) begin
                sg_seen = data_out_i;
                oe_seen = data_oe_i;
                ->frame_done;
            end
            if (bit_n == 91) data_o = bac_i;
            else if (bit_n == 24) data_o = frame_n[1];
            else if (bit_n == 25) data_o = frame_n[0];
            else data_o = ~data_o; // Toggling so a stale level cannot pass
            #400;
            bit_clock_o = 1'b0;
            frame_sync_o = (bit_n == 95);
        end
    end
endmodule

// ==== bench/stop_go_bit_control_test.sv ====
// Self-checking bench for the stop/go bit control
module stop_go_bit_control_test
    import stop_go_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
    logic hmode = 1'b0, rxs = 1'b0, bac = 1'b1;
    logic fs, bclk, din, awr, wrdy, bv, arr, rv, dout, doe;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, rdat, rd_d, seed = 32'h0000_71a6;
    logic [1:0] br, rr, resp;
    eoc_msg_t eoc = '0;
    d_up_t dup;
    int error_cnt = 0, checked = 0, len;

    stop_go_ctrl #(.T1_CYC(20), .TD1_MIN_CYC(40), .TD1_STEP_CYC(4)) uut (
        .CLOCK_I(clk), .RESET_I(rst), .AXI_AWADDR_I(awa), .AXI_AWVALID_I(awv), .AXI_AWREADY_O(awr),
        .AXI_WDATA_I(wd), .AXI_WSTRB_I(4'hf), .AXI_WVALID_I(wv), .AXI_WREADY_O(wrdy),
        .AXI_BRESP_O(br), .AXI_BVALID_O(bv), .AXI_BREADY_I(bry), .AXI_ARADDR_I(ara),
        .AXI_ARVALID_I(arv), .AXI_ARREADY_O(arr), .AXI_RDATA_O(rdat), .AXI_RRESP_O(rr),
        .AXI_RVALID_O(rv), .AXI_RREADY_I(rry), .FRAME_SYNC_I(fs), .BIT_CLOCK_I(bclk),
        .DATA_IN_I(din), .DATA_OUT_O(dout), .DATA_OUT_OE_O(doe), .HOST_BUS_MODE_SELECT_I(hmode),
        .RX_SYNC_I(rxs), .EOC_MSG_I(eoc), .D_UP_O(dup));

    frame_partner p (.bit_clock_o(bclk), .frame_sync_o(fs), .data_o(din), .data_out_i(dout),
        .data_oe_i(doe), .bac_i(bac));

    initial begin
        forever #50 clk = ~clk;
    end

    // ----
    // Shared tasks
    // ----
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exp);
        @(posedge clk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        // No cycle count assumed: only the watchdog ends a hung wait
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
        end while (bv !== 1'b1);
        check(32'(br), 32'(exp));
        bry <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a);
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        do begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
        end while (rv !== 1'b1);
        rd_d = rdat;
        resp = rr;
        rry <= 1'b0;
    endtask

    task automatic send_eoc(input logic [7:0] c, input logic [3:0] ps);
        @(posedge clk);
        eoc <= '{1'b1, c, ps};
        @(posedge clk);
        eoc <= '0;
    endtask

    // Waits for the frame under way to pass its stop/go bit first: a state change may land mid-frame
    task automatic frame_chk(input logic sg, input logic oe, input logic zf);
        @(p.frame_done);
        @(posedge clk);
        while (dup.valid !== 1'b1) begin
            @(posedge clk);
        end
        check(32'(dup.bits), zf ? 32'h0 : 32'(p.frame_n[1:0]));
        @(p.frame_done);
        check(32'(p.oe_pre), 32'h0);
        check(32'(p.oe_seen), 32'(oe));
        if (oe) check(32'(p.sg_seen), 32'(sg));
    endtask

    task automatic state_is(input logic [5:0] s);
        axi_rd(STATUS_OFFSET);
        check(32'(rd_d[5:0]), 32'(s));
    endtask

    task automatic stop_test;
        $display("checked %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // ----
    // Scenarios
    // ----
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        axi_rd(CTRL_OFFSET);
        check(rd_d, 32'h0);
        axi_rd(STATUS_OFFSET);
        check(32'(rd_d[6:0]), 32'h41);
        axi_rd(8'h08);
        check(32'(resp), 32'(RESP_SLVERR));
        axi_wr(8'h0c, 32'h1, RESP_SLVERR);
        axi_wr(STATUS_OFFSET, 32'h1, RESP_OKAY);
        frame_chk(1'b0, 1'b0, 1'b0);
        $display("test reset finished");
        seed = xs(seed);
        axi_wr(CTRL_OFFSET, {seed[31:4], 4'h1}, RESP_OKAY);
        axi_rd(CTRL_OFFSET);
        check(rd_d, 32'h1);
        frame_chk(1'b1, 1'b1, 1'b0);
        @(posedge clk);
        rxs <= 1'b1;
        frame_chk(1'b0, 1'b1, 1'b0);
        send_eoc(8'h26, seed[3:0]);
        state_is(ST_GO);
        for (int i = 0; i < 2; i++) begin
            bac = i[0];
            // Two frames: the new level may miss the bit of the frame under way
            repeat (2) @(p.frame_done);
            repeat (6) @(posedge clk);
            axi_rd(STATUS_OFFSET);
            check(32'(rd_d[STAT_BAC_BIT]), 32'(i[0]));
        end
        $display("test sync finished");
        // Timers are shortened, so a wait phase never spans a frame
        for (int i = 0; i < 2; i++) begin
            send_eoc(EOC_STOP_CODE, 4'h0);
            repeat (10) @(posedge clk);
            axi_rd(STATUS_OFFSET);
            check(32'({rd_d[STAT_T1_BIT], rd_d[5:0]}), 32'({1'b1, ST_WAIT_STOP}));
            repeat (12) @(posedge clk);
            state_is(ST_STOPPED);
            frame_chk(1'b1, 1'b1, 1'b1);
            seed = xs(seed);
            len = 40 + 4 * int'(seed[3:0]);
            send_eoc(EOC_GO_CODE, seed[3:0]);
            repeat (len - 8) @(posedge clk);
            axi_rd(STATUS_OFFSET);
            check(32'({rd_d[STAT_TD1_BIT], rd_d[5:0]}), 32'({1'b1, ST_RESUME}));
            repeat (12) @(posedge clk);
            state_is(ST_GO);
        end
        $display("test stop go finished");
        axi_wr(CTRL_OFFSET, 32'h3, RESP_OKAY);
        repeat (30) @(posedge clk);
        axi_rd(STATUS_OFFSET);
        check(32'({rd_d[STAT_HOST_BUS_MODE_SELECT_BIT], rd_d[5:0]}), 32'({1'b0, ST_GO}));
        hmode <= 1'b1;
        repeat (40) @(posedge clk);
        axi_rd(STATUS_OFFSET);
        check(32'({rd_d[STAT_HOST_BUS_MODE_SELECT_BIT], rd_d[5:0]}), 32'({1'b1, ST_STOPPED}));
        axi_wr(CTRL_OFFSET, 32'h1, RESP_OKAY);
        send_eoc(EOC_GO_CODE, 4'h0);
        repeat (60) @(posedge clk);
        state_is(ST_GO);
        axi_wr(CTRL_OFFSET, 32'h0, RESP_OKAY);
        frame_chk(1'b0, 1'b0, 1'b0);
        state_is(ST_OFF);
        $display("test host mode finished");
        stop_test();
    end

    initial begin
        #5_000_000;
        error_cnt++;
        stop_test();
    end
endmodule
